// *** fbpf_pkg.sv ***
// Register map, field layout and types of the frame-buffer pixel format control.
// Operation
// - Cache bypass bit 0 uses the parameter cache, 1 bypasses it.
// - Sort bits select no sort, group by offset, or tag then offset.
// - Border area shows the border colour register, chroma in bit 24, reset zero.
// - Divider bit 0 gives pixel clock at half video clock, 1 at full.
// - For 32-bit read data, chroma is low when alpha is below the limit.
// - Short colour components are widened to 8 bits with the fill value.
// - Read format selects 0555, 565, packed 888 or 0888 pixels.
// - 555 fills three low bits; 565 green takes fill bits 1:0.
// - Line repeat set reads each line twice, clear reads it once.
// - Frame reads happen only while the read enable bit is set.
// - In 1555 writes the alpha bit is 1 when alpha reaches the limit.
// - 0555 writes carry K bit 7 in bit 15; 0888 writes carry full K.
// - 16-bit writes dither when enabled, else drop the low bits.
// - Write format selects seven packings; code 7 is reserved.
package fbpf_pkg;
	localparam logic [31:0] SPAN_SORT_CONFIG_ADDR    = 32'h005F8030;
	localparam logic [31:0] BORDER_COLOUR_ADDR       = 32'h005F8040;
	localparam logic [31:0] FRAME_READ_CONTROL_ADDR  = 32'h005F8044;
	localparam logic [31:0] FRAME_WRITE_CONTROL_ADDR = 32'h005F8048;
	localparam logic [31:0] SPAN_MASK                = 32'h00010101;
	localparam logic [31:0] BORDER_MASK              = 32'h01FFFFFF;
	localparam logic [31:0] RCTL_MASK                = 32'h00FFFF7F;
	localparam logic [31:0] WCTL_MASK                = 32'h00FFFF0F;
	localparam int          HTRANS_ACTIVE_BIT        = 1;
	localparam int          SPAN_SORT_BIT            = 0;
	localparam int          OFFSET_SORT_BIT          = 8;
	localparam int          CACHE_BYPASS_BIT         = 16;
	localparam int          BORDER_BLUE_LSB          = 0;
	localparam int          BORDER_GREEN_LSB         = 8;
	localparam int          BORDER_RED_LSB           = 16;
	localparam int          BORDER_CHROMA_BIT        = 24;
	localparam int          FRAME_READ_ON_BIT        = 0;
	localparam int          LINE_REPEAT_BIT          = 1;
	localparam int          READ_FORMAT_LSB          = 2;
	localparam int          LOW_FILL_LSB             = 4;
	localparam int          KEY_LIMIT_LSB            = 8;
	localparam int          STRIP_SIZE_LSB           = 16;
	localparam int          STRIP_ON_BIT             = 22;
	localparam int          CLOCK_DIV_BIT            = 23;
	localparam int          WRITE_FORMAT_LSB         = 0;
	localparam int          DITHER_BIT               = 3;
	localparam int          K_BYTE_LSB               = 8;
	localparam int          ALPHA_LIMIT_LSB          = 16;
	localparam int          STRIP_UNIT_SHIFT         = 5;
	localparam logic [1:0]  RD_0555                  = 2'h0;
	localparam logic [1:0]  RD_565                   = 2'h1;
	localparam logic [1:0]  RD_888                   = 2'h2;
	localparam logic [1:0]  RD_0888                  = 2'h3;
	localparam logic [2:0]  WR_0555                  = 3'h0;
	localparam logic [2:0]  WR_565                   = 3'h1;
	localparam logic [2:0]  WR_4444                  = 3'h2;
	localparam logic [2:0]  WR_1555                  = 3'h3;
	localparam logic [2:0]  WR_888                   = 3'h4;
	localparam logic [2:0]  WR_0888                  = 3'h5;
	localparam logic [2:0]  WR_8888                  = 3'h6;
	localparam logic [2:0]  WR_RESERVED              = 3'h7;
	localparam logic [63:0] BAYER                    = 64'h5D7F91B36E4CA280;
	typedef enum logic [1:0] {SORT_NONE, SORT_OFFSET, SORT_TAG_OFFSET} sort_mode_e;
	typedef enum logic [2:0] {SEL_NONE, SEL_SPAN, SEL_BORDER, SEL_RCTL, SEL_WCTL} reg_sel_e;
endpackage

// *** framebuffer_pixel_format_control.sv ***
// Frame-buffer pixel format control with its AHB-Lite register slave.
`timescale 1ns/100ps
module framebuffer_pixel_format_control (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        video_clock_en,
	output logic             pixel_clock_en,
	input  wire logic        frame_start,
	input  wire logic        line_end,
	output logic             fb_read_req,
	output logic [10:0]      fb_read_line,
	input  wire logic        rd_in_valid,
	input  wire logic [31:0] rd_in_data,
	input  wire logic        border_active,
	output logic             pix_valid,
	output logic [7:0]       pix_r,
	output logic [7:0]       pix_g,
	output logic [7:0]       pix_b,
	output logic             pix_chroma,
	input  wire logic        wr_in_valid,
	input  wire logic [7:0]  wr_a,
	input  wire logic [7:0]  wr_r,
	input  wire logic [7:0]  wr_g,
	input  wire logic [7:0]  wr_b,
	input  wire logic [1:0]  wr_x,
	input  wire logic [1:0]  wr_y,
	output logic             wout_valid,
	output logic [31:0]      wout_data,
	output logic [2:0]       wout_bytes,
	output logic             cache_bypass,
	output fbpf_pkg::sort_mode_e sort_mode,
	output logic             strip_buffer_on,
	output logic [10:0]      strip_lines
);

	typedef struct packed {
		logic [31:0]          span;
		logic [31:0]          border;
		logic [31:0]          rctl;
		logic [31:0]          wctl;
		logic                 wr_pend;
		fbpf_pkg::reg_sel_e   wsel;
		logic [31:0]          hrdata;
		logic                 hreadyout;
		logic                 hresp;
		logic                 pclk_phase;
		logic                 pclk_en;
		logic [10:0]          read_line;
		logic                 line_pass;
		logic                 fb_read_req;
		logic                 pix_valid;
		logic [7:0]           pix_r;
		logic [7:0]           pix_g;
		logic [7:0]           pix_b;
		logic                 pix_chroma;
		logic                 wout_valid;
		logic [31:0]          wout_data;
		logic [2:0]           wout_bytes;
		logic                 cache_bypass;
		fbpf_pkg::sort_mode_e sort_mode;
		logic                 strip_on;
		logic [10:0]          strip_lines;
	} state_s;

	state_s             s;
	state_s             next_s;
	fbpf_pkg::reg_sel_e sel;
	logic [3:0]         bv;
	logic               dith_on;
	logic [7:0]         r4, g4, b4, a4;
	logic [7:0]         r5, g5, b5, g6;
	logic [2:0]         wfmt;
	logic [1:0]         rfmt;
	logic [2:0]         fill;
	logic [7:0]         k_byte;
	logic [7:0]         alpha_limit;
	logic [7:0]         key_limit;

	// Maps a byte address onto one of the four registers.
	function automatic fbpf_pkg::reg_sel_e sel_of(input logic [31:0] a);
		if (a == fbpf_pkg::SPAN_SORT_CONFIG_ADDR)
			sel_of = fbpf_pkg::SEL_SPAN;
		else if (a == fbpf_pkg::BORDER_COLOUR_ADDR)
			sel_of = fbpf_pkg::SEL_BORDER;
		else if (a == fbpf_pkg::FRAME_READ_CONTROL_ADDR)
			sel_of = fbpf_pkg::SEL_RCTL;
		else if (a == fbpf_pkg::FRAME_WRITE_CONTROL_ADDR)
			sel_of = fbpf_pkg::SEL_WCTL;
		else
			sel_of = fbpf_pkg::SEL_NONE;
	endfunction

	// Adds a scaled ordered-dither step and saturates at full scale.
	function automatic logic [7:0] dith(input logic [7:0] c, input logic [3:0] d,
		input logic [1:0] sh, input logic on);
		logic [8:0] sum;
		sum = {1'b0, c} + (on ? 9'(d >> sh) : 9'h000);
		dith = sum[8] ? 8'hFF : sum[7:0];
	endfunction

	// Field views of the control registers and the dithered components.
	always_comb begin
		wfmt        = s.wctl[fbpf_pkg::WRITE_FORMAT_LSB +: 3];
		k_byte      = s.wctl[fbpf_pkg::K_BYTE_LSB +: 8];
		alpha_limit = s.wctl[fbpf_pkg::ALPHA_LIMIT_LSB +: 8];
		rfmt        = s.rctl[fbpf_pkg::READ_FORMAT_LSB +: 2];
		fill        = s.rctl[fbpf_pkg::LOW_FILL_LSB +: 3];
		key_limit   = s.rctl[fbpf_pkg::KEY_LIMIT_LSB +: 8];
		bv          = fbpf_pkg::BAYER[{wr_y, wr_x, 2'h0} +: 4];
		dith_on     = s.wctl[fbpf_pkg::DITHER_BIT] && !wfmt[2];
		r4          = dith(wr_r, bv, 2'h0, dith_on);
		g4          = dith(wr_g, bv, 2'h0, dith_on);
		b4          = dith(wr_b, bv, 2'h0, dith_on);
		a4          = dith(wr_a, bv, 2'h0, dith_on);
		r5          = dith(wr_r, bv, 2'h1, dith_on);
		g5          = dith(wr_g, bv, 2'h1, dith_on);
		b5          = dith(wr_b, bv, 2'h1, dith_on);
		g6          = dith(wr_g, bv, 2'h2, dith_on);
	end

	// Next-state logic of the whole block.
	always_comb begin
		next_s = s;
		sel    = fbpf_pkg::SEL_NONE;

		// Data phase of a write lands in the register chosen at its address phase.
		if (s.wr_pend) begin
			unique case (s.wsel)
				fbpf_pkg::SEL_SPAN:   next_s.span   = hwdata & fbpf_pkg::SPAN_MASK;
				fbpf_pkg::SEL_BORDER: next_s.border = hwdata & fbpf_pkg::BORDER_MASK;
				fbpf_pkg::SEL_RCTL:   next_s.rctl   = hwdata & fbpf_pkg::RCTL_MASK;
				fbpf_pkg::SEL_WCTL:   next_s.wctl   = hwdata & fbpf_pkg::WCTL_MASK;
				fbpf_pkg::SEL_NONE:   ;
			endcase
		end

		// Address phase; a read sees any write still in its data phase.
		next_s.wr_pend = 1'b0;
		next_s.wsel    = fbpf_pkg::SEL_NONE;
		if (hsel && htrans[fbpf_pkg::HTRANS_ACTIVE_BIT] && hready) begin
			sel = sel_of(haddr);
			if (hwrite) begin
				next_s.wr_pend = 1'b1;
				next_s.wsel    = sel;
			end else begin
				unique case (sel)
					fbpf_pkg::SEL_SPAN:   next_s.hrdata = next_s.span;
					fbpf_pkg::SEL_BORDER: next_s.hrdata = next_s.border;
					fbpf_pkg::SEL_RCTL:   next_s.hrdata = next_s.rctl;
					fbpf_pkg::SEL_WCTL:   next_s.hrdata = next_s.wctl;
					fbpf_pkg::SEL_NONE:   next_s.hrdata = '0;
				endcase
			end
		end
		next_s.hreadyout = 1'b1;
		next_s.hresp     = 1'b0;

		// Parameter cache use and span sort mode; the prohibited pair sorts nothing.
		next_s.cache_bypass = s.span[fbpf_pkg::CACHE_BYPASS_BIT];
		unique case ({s.span[fbpf_pkg::OFFSET_SORT_BIT], s.span[fbpf_pkg::SPAN_SORT_BIT]})
			2'h1:    next_s.sort_mode = fbpf_pkg::SORT_OFFSET;
			2'h3:    next_s.sort_mode = fbpf_pkg::SORT_TAG_OFFSET;
			default: next_s.sort_mode = fbpf_pkg::SORT_NONE;
		endcase

		// Strip buffer settings are passed on, size in lines. The size field's low bit is
		// stored but not used, so the count of 32-line units starts one bit above it.
		next_s.strip_on    = s.rctl[fbpf_pkg::STRIP_ON_BIT];
		next_s.strip_lines = 11'(s.rctl[fbpf_pkg::STRIP_SIZE_LSB + 1 +: 5])
			<< fbpf_pkg::STRIP_UNIT_SHIFT;

		// Pixel clock enable: every video clock, or every second one.
		next_s.pclk_en = 1'b0;
		if (video_clock_en) begin
			if (s.rctl[fbpf_pkg::CLOCK_DIV_BIT]) begin
				next_s.pclk_en = 1'b1;
			end else begin
				next_s.pclk_phase = !s.pclk_phase;
				next_s.pclk_en    = s.pclk_phase;
			end
		end

		// Line sequencing; with repeat each line is requested on two passes.
		next_s.fb_read_req = s.rctl[fbpf_pkg::FRAME_READ_ON_BIT];
		if (!s.rctl[fbpf_pkg::FRAME_READ_ON_BIT] || frame_start) begin
			next_s.read_line = '0;
			next_s.line_pass = 1'b0;
		end else if (line_end) begin
			if (s.rctl[fbpf_pkg::LINE_REPEAT_BIT] && !s.line_pass) begin
				next_s.line_pass = 1'b1;
			end else begin
				next_s.line_pass = 1'b0;
				next_s.read_line = s.read_line + 11'h001;
			end
		end

		// Read pixel unpacking; the border colour overrides frame data.
		next_s.pix_valid  = 1'b0;
		next_s.pix_chroma = 1'b0;
		if (border_active) begin
			next_s.pix_valid  = 1'b1;
			next_s.pix_r      = s.border[fbpf_pkg::BORDER_RED_LSB +: 8];
			next_s.pix_g      = s.border[fbpf_pkg::BORDER_GREEN_LSB +: 8];
			next_s.pix_b      = s.border[fbpf_pkg::BORDER_BLUE_LSB +: 8];
			next_s.pix_chroma = s.border[fbpf_pkg::BORDER_CHROMA_BIT];
		end else if (rd_in_valid && s.rctl[fbpf_pkg::FRAME_READ_ON_BIT]) begin
			next_s.pix_valid = 1'b1;
			unique case (rfmt)
				fbpf_pkg::RD_0555: begin
					next_s.pix_r = {rd_in_data[14:10], fill};
					next_s.pix_g = {rd_in_data[9:5], fill};
					next_s.pix_b = {rd_in_data[4:0], fill};
				end
				fbpf_pkg::RD_565: begin
					next_s.pix_r = {rd_in_data[15:11], fill};
					next_s.pix_g = {rd_in_data[10:5], fill[1:0]};
					next_s.pix_b = {rd_in_data[4:0], fill};
				end
				fbpf_pkg::RD_888: begin
					next_s.pix_r = rd_in_data[23:16];
					next_s.pix_g = rd_in_data[15:8];
					next_s.pix_b = rd_in_data[7:0];
				end
				fbpf_pkg::RD_0888: begin
					next_s.pix_r      = rd_in_data[23:16];
					next_s.pix_g      = rd_in_data[15:8];
					next_s.pix_b      = rd_in_data[7:0];
					next_s.pix_chroma = rd_in_data[31:24] >= key_limit;
				end
			endcase
		end

		// Write pixel packing; the reserved code produces no output.
		next_s.wout_valid = wr_in_valid && (wfmt != fbpf_pkg::WR_RESERVED);
		unique case (wfmt)
			fbpf_pkg::WR_0555: begin
				next_s.wout_data  = {16'h0000, k_byte[7], r5[7:3], g5[7:3], b5[7:3]};
				next_s.wout_bytes = 3'h2;
			end
			fbpf_pkg::WR_565: begin
				next_s.wout_data  = {16'h0000, r5[7:3], g6[7:2], b5[7:3]};
				next_s.wout_bytes = 3'h2;
			end
			fbpf_pkg::WR_4444: begin
				next_s.wout_data  = {16'h0000, a4[7:4], r4[7:4], g4[7:4], b4[7:4]};
				next_s.wout_bytes = 3'h2;
			end
			fbpf_pkg::WR_1555: begin
				next_s.wout_data  = {16'h0000, wr_a >= alpha_limit,
					r5[7:3], g5[7:3], b5[7:3]};
				next_s.wout_bytes = 3'h2;
			end
			fbpf_pkg::WR_888: begin
				next_s.wout_data  = {8'h00, wr_r, wr_g, wr_b};
				next_s.wout_bytes = 3'h3;
			end
			fbpf_pkg::WR_0888: begin
				next_s.wout_data  = {k_byte, wr_r, wr_g, wr_b};
				next_s.wout_bytes = 3'h4;
			end
			fbpf_pkg::WR_8888: begin
				next_s.wout_data  = {wr_a, wr_r, wr_g, wr_b};
				next_s.wout_bytes = 3'h4;
			end
			fbpf_pkg::WR_RESERVED: begin
				next_s.wout_data  = '0;
				next_s.wout_bytes = 3'h0;
			end
		endcase

		// Synchronous reset clears everything; the bus reads ready.
		if (rst) begin
			next_s           = '0;
			next_s.hreadyout = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		s <= next_s;
	end

	// Outputs come straight from the state register.
	assign hreadyout       = s.hreadyout;
	assign hrdata          = s.hrdata;
	assign hresp           = s.hresp;
	assign pixel_clock_en  = s.pclk_en;
	assign fb_read_req     = s.fb_read_req;
	assign fb_read_line    = s.read_line;
	assign pix_valid       = s.pix_valid;
	assign pix_r           = s.pix_r;
	assign pix_g           = s.pix_g;
	assign pix_b           = s.pix_b;
	assign pix_chroma      = s.pix_chroma;
	assign wout_valid      = s.wout_valid;
	assign wout_data       = s.wout_data;
	assign wout_bytes      = s.wout_bytes;
	assign cache_bypass    = s.cache_bypass;
	assign sort_mode       = s.sort_mode;
	assign strip_buffer_on = s.strip_on;
	assign strip_lines     = s.strip_lines;

endmodule // framebuffer_pixel_format_control

// *** fbpf_assertions.sv ***
// Port-level assertions for the frame-buffer pixel format control.
`timescale 1ns/100ps
module fbpf_assertions (
	input wire logic            clk,
	input wire logic            rst,
	input wire logic            hsel,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic            hready,
	input wire logic            video_clock_en,
	input wire logic            pixel_clock_en,
	input wire logic            frame_start,
	input wire logic            line_end,
	input wire logic            fb_read_req,
	input wire logic [10:0]     fb_read_line,
	input wire logic            rd_in_valid,
	input wire logic            border_active,
	input wire logic            pix_valid,
	input wire logic            wr_in_valid,
	input wire logic            wout_valid,
	input wire logic [31:0]     wout_data,
	input wire logic [2:0]      wout_bytes,
	input fbpf_pkg::sort_mode_e sort_mode
);
	// Every check runs on the system clock and sleeps through reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Helper terms: a write address phase taken on the bus, and a cause for a pixel.
	logic bus_write;
	logic pix_cause;
	assign bus_write = hsel && htrans[1] && hwrite && hready;
	assign pix_cause = rd_in_valid || border_active;
	// Read side: a pixel appears only for an accepted word or a border cycle.
	property p_border; border_active |=> pix_valid; endproperty
	a_border: assert property (p_border) else $error("border cycle gave no pixel");
	property p_cause; pix_valid |-> $past(pix_cause); endproperty
	a_cause: assert property (p_cause) else $error("pixel without a cause");
	property p_off;
		(rd_in_valid && !border_active && !fb_read_req) ##1 !fb_read_req |-> !pix_valid;
	endproperty
	a_off: assert property (p_off) else $error("pixel while reads are off");
	property p_pclk; pixel_clock_en |-> $past(video_clock_en); endproperty
	a_pclk: assert property (p_pclk) else $error("pixel clock without video clock");
	// The sort mode moves only three cycles after a write address phase.
	property p_sort; $changed(sort_mode) |-> $past(bus_write, 3); endproperty
	a_sort: assert property (p_sort) else $error("sort mode moved without a write");
	// Write side: every packed word answers a rendered pixel with a legal size.
	property p_wcause;
		wout_valid |-> $past(wr_in_valid) && wout_bytes inside {3'h2, 3'h3, 3'h4};
	endproperty
	a_wcause: assert property (p_wcause) else $error("bad packed pixel");
	property p_wnext; wr_in_valid |=> wout_valid || wout_data == 32'h0; endproperty
	a_wnext: assert property (p_wnext) else $error("rendered pixel lost");
	// Line fetch returns to the top on a frame start or while reads are off.
	property p_frame; frame_start ##1 !line_end |=> fb_read_line == 11'h0; endproperty
	a_frame: assert property (p_frame) else $error("frame start kept the line");
	property p_lineoff; !fb_read_req |-> fb_read_line == 11'h0; endproperty
	a_lineoff: assert property (p_lineoff) else $error("line moved while off");
	c_border: cover property (border_active ##1 pix_valid);
	c_word: cover property (wout_valid && wout_bytes == 3'h4);
	c_line: cover property (line_end ##2 fb_read_line != 11'h0);
endmodule // fbpf_assertions
bind framebuffer_pixel_format_control fbpf_assertions u_fbpf_assertions (
	.clk, .rst, .hsel, .htrans, .hwrite, .hready, .video_clock_en, .pixel_clock_en,
	.frame_start, .line_end, .fb_read_req,
	.fb_read_line, .rd_in_valid, .border_active, .pix_valid, .wr_in_valid, .wout_valid,
	.wout_data, .wout_bytes, .sort_mode
);

// *** pixel_display_model.sv ***
// Behavioural display that makes the video clock and counts clock ticks.
`timescale 1ns/100ps
module pixel_display_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] gap,
	input  wire logic       clear,
	input  wire logic       pixel_clock_en,
	output logic            video_clock_en,
	output int              vclk_count,
	output int              pclk_count
);
	logic [1:0] phase;
	// The video clock ticks every gap plus one cycles, so a larger gap is a slower display.
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			phase <= 2'h0;
			video_clock_en <= 1'b0;
			vclk_count <= 0;
			pclk_count <= 0;
		end else begin
			phase <= (phase >= gap) ? 2'h0 : phase + 2'h1;
			video_clock_en <= (phase >= gap);
			vclk_count <= vclk_count + int'(video_clock_en);
			pclk_count <= pclk_count + int'(pixel_clock_en);
		end
	end
endmodule // pixel_display_model

// *** framebuffer_pixel_format_control_tb.sv ***
// Self-checking bench for the frame-buffer pixel format control.
`timescale 1ns/100ps
module framebuffer_pixel_format_control_tb;
	localparam logic [31:0] RCTL = fbpf_pkg::FRAME_READ_CONTROL_ADDR;
	localparam logic [31:0] WCTL = fbpf_pkg::FRAME_WRITE_CONTROL_ADDR;
	logic        clk, rst, hsel, hwrite, vclr, frame_start, line_end, rd_in_valid;
	logic        border_active, wr_in_valid, hreadyout, hresp, video_clock_en, pixel_clock_en;
	logic        fb_read_req, pix_valid, pix_chroma, wout_valid, cache_bypass, strip_buffer_on;
	logic [1:0]  htrans, wr_x, wr_y, gap;
	logic [2:0]  wout_bytes;
	logic [7:0]  pix_r, pix_g, pix_b;
	logic [10:0] fb_read_line, strip_lines;
	logic [31:0] haddr, hwdata, hrdata, rd_in_data, wout_data, rd;
	fbpf_pkg::sort_mode_e sort_mode;
	int          bad_count, total_checks, vcnt, pcnt;
	logic [31:0] ra [4] = '{fbpf_pkg::SPAN_SORT_CONFIG_ADDR, fbpf_pkg::BORDER_COLOUR_ADDR, RCTL, WCTL};
	logic [31:0] rm [4] = '{fbpf_pkg::SPAN_MASK, fbpf_pkg::BORDER_MASK, fbpf_pkg::RCTL_MASK,
		fbpf_pkg::WCTL_MASK};
	logic [31:0] rc [5] = '{32'h51, 32'h65, 32'h09, 32'h800D, 32'h800D};
	logic [31:0] rv [5] = '{32'h555F, 32'hAD4B, 32'h123456, 32'h7FABCDEF, 32'h80ABCDEF};
	logic [31:0] rx [5] = '{32'h02AD55FD, 32'h02AEAA5E, 32'h02123456, 32'h02ABCDEF, 32'h03ABCDEF};
	logic [31:0] wx [7] = '{32'h7965, 32'hF2C5, 32'h9F52, 32'hF965, 32'hF35A2D, 32'h55F35A2D,
		32'h9CF35A2D};

	framebuffer_pixel_format_control u_dut (
		.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .video_clock_en, .pixel_clock_en, .frame_start, .line_end,
		.fb_read_req, .fb_read_line, .rd_in_valid, .rd_in_data, .border_active, .pix_valid,
		.pix_r, .pix_g, .pix_b, .pix_chroma, .wr_in_valid, .wr_a(8'h9C), .wr_r(8'hF3),
		.wr_g(8'h5A), .wr_b(8'h2D), .wr_x, .wr_y, .wout_valid, .wout_data, .wout_bytes,
		.cache_bypass, .sort_mode, .strip_buffer_on, .strip_lines
	);
	pixel_display_model u_display (
		.clk, .rst, .gap, .clear(vclr), .pixel_clock_en, .video_clock_en, .vclk_count(vcnt),
		.pclk_count(pcnt)
	);

	// Free-running system clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Comparison, verdict and bus helpers.
	function automatic logic [31:0] px();
		return {6'h0, pix_valid, pix_chroma, pix_r, pix_g, pix_b};
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			check("hready wait", 32'h1, 32'h0);
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		check("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rpix(input logic [31:0] d, input logic bd);
		@(posedge clk);
		rd_in_valid <= !bd;
		rd_in_data <= d;
		border_active <= bd;
		@(posedge clk);
		rd_in_valid <= 1'b0;
		border_active <= 1'b0;
		#1;
	endtask
	task automatic wpix();
		@(posedge clk);
		wr_in_valid <= 1'b1;
		@(posedge clk);
		wr_in_valid <= 1'b0;
		#1;
	endtask
	task automatic pulse(input logic fs, input logic [10:0] exp);
		@(posedge clk);
		frame_start <= fs;
		line_end <= !fs;
		@(posedge clk);
		frame_start <= 1'b0;
		line_end <= 1'b0;
		@(posedge clk);
		#1;
		check("read line", {21'h0, exp}, {21'h0, fb_read_line});
	endtask

	// Main sequence: registers, controls, read pixels, lines, clock and write packing.
	initial begin
		rst = 1'b1;
		{hsel, hwrite, vclr, frame_start, line_end, rd_in_valid, border_active, wr_in_valid} = '0;
		{htrans, wr_x, wr_y, haddr, hwdata, rd_in_data} = '0;
		gap = 2'h1;
		bad_count = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, ra[i], 32'h0);
			check("reset value", 32'h0, rd);
			bus(1'b1, ra[i], 32'hFFFFFFFF);
			bus(1'b0, ra[i], 32'h0);
			check("writable bits", rm[i], rd);
			bus(1'b1, ra[i], 32'h0);
		end
		bus(1'b1, 32'h005F803C, 32'hFFFFFFFF);
		bus(1'b0, 32'h005F803C, 32'h0);
		check("unmapped", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ra[0], (i == 3) ? 32'h10101 : (i == 2) ? 32'h101 : 32'(i));
			settle();
			check("sort", (i == 3) ? 32'h6 : 32'(i), {29'h0, cache_bypass, sort_mode});
		end
		$display("test registers done");
		bus(1'b1, ra[1], 32'h01123456);
		rpix(32'h0, 1'b1);
		check("border pixel", 32'h03123456, px());
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, RCTL, rc[i]);
			settle();
			rpix(rv[i], 1'b0);
			check("read pixel", rx[i], px());
		end
		bus(1'b1, RCTL, 32'h800C);
		settle();
		rpix(32'h80ABCDEF, 1'b0);
		check("read while off", 32'h0, {30'h0, pix_valid, fb_read_req});
		$display("test pixels done");
		bus(1'b1, RCTL, 32'h3);
		settle();
		for (int i = 0; i < 5; i++) pulse(i == 0, 11'(i / 2));
		bus(1'b1, RCTL, 32'h1);
		settle();
		for (int i = 0; i < 3; i++) pulse(i == 0, 11'(i));
		bus(1'b1, RCTL, 32'h00420000);
		settle();
		pulse(1'b0, 11'h0);
		check("strip", 32'h820, {20'h0, strip_buffer_on, strip_lines});
		for (int d = 0; d < 2; d++) begin
			bus(1'b1, RCTL, 32'(d) << 23);
			gap <= 2'(d + 1);
			settle();
			@(posedge clk);
			vclr <= 1'b1;
			@(posedge clk);
			vclr <= 1'b0;
			repeat (60) @(posedge clk);
			#1;
			check("pixel clock", 32'h1, {31'h0, (pcnt * (2 - d) - vcnt) inside {[-2:2]}});
		end
		$display("test lines and clock done");
		// Only the seven legal packings are programmed; the reserved code is never set.
		for (int f = 0; f < 7; f++) begin
			bus(1'b1, WCTL, {16'h009C, 8'h55, 5'h0, 3'(f)});
			settle();
			wpix();
			check("packed pixel", wx[f], wout_data);
			check("bytes", (f < 4) ? 32'h2 : (f == 4) ? 32'h3 : 32'h4, 32'(wout_bytes));
			check("packed valid", 32'h1, {31'h0, wout_valid});
		end
		bus(1'b1, WCTL, {16'h009D, 8'h55, 5'h0, fbpf_pkg::WR_1555});
		settle();
		wpix();
		check("alpha below limit", 32'h7965, wout_data);
		bus(1'b1, WCTL, 32'h009C5509);
		wr_x <= 2'h1;
		settle();
		wpix();
		check("dithered pixel", 32'hF2E6, wout_data);
		$display("test writes done");
		tally_and_finish();
	end
endmodule // framebuffer_pixel_format_control_tb
